// file: osc_input_config_divider.sv
// Oscillator / input buffer configuration word with reference divider.
// Assumes an Avalon-MM master on ref_clk_in and an asynchronous
// reference level on osc_in_terminal_in.
//
// Behaviour
// - Ratio zero bypasses; 2..31 divide the reference; one is reserved.
// - Divider run bit is active high; cleared holds divider set; resets one.
// - Clearing run stops divided clock unless ratio zero or one bypasses it.
// - Buffer-off zero: hardware enables core buffer at startup, keeps it.
// - Buffer-off one forces the core buffer off; debug only.
// - Mode bit: zero input buffer, one crystal; resets to crystal.
// - Two 6-bit tuning capacitance codes, monotonic, reset 0x28.
// - Gain code enables zero to three boost amplifiers in startup.
// - Single-ended bit: zero differential, one CMOS; resets zero.
// - Pair bit: zero PMOS pair, one NMOS pair; resets one.
// - 3-bit series resistor code limits drive; resets four.
//
// Decided for this implementation: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module osc_input_config_divider
    import osc_cfg_pkg::*;
#(
    parameter int START_CYCLES = STARTUP_CYCLES
)
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [ADDR_W-1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [DATA_W-1:0] avs_writedata_in,
    input wire logic [3:0] avs_byteenable_in,
    output logic [DATA_W-1:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    input wire logic osc_in_terminal_in,
    output logic ref_div_clk_out,
    output logic osc_mode_xtal_out,
    output logic [CAP_W-1:0] tuning_cap_in_terminal_out,
    output logic [CAP_W-1:0] tuning_cap_out_terminal_out,
    output logic [AMP_COUNT-1:0] boost_amp_en_out,
    output logic [RES_W-1:0] series_resistor_code_out,
    output logic buffer_dc_bias_on_out,
    output logic single_ended_select_out,
    output logic input_pair_select_out,
    output logic osc_core_buffer_en_out
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [DATA_W-1:0] cfg_r;
    logic [DATA_W-1:0] cfg_nxt;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic ack_r;
    logic ack_nxt;
    logic ref_meta_r;
    logic ref_sync_r;
    logic startup_done;
    logic [ST_W-1:0] status_word;
    div_ctrl_if div_ctrl ();
    // Field map and divider bundle are fixed at these widths
    if (RATIO_W != 5 || DATA_W != 32) begin : g_bad_map
        $error("field map needs a 32-bit word and 5-bit ratio");
    end
    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // One wait state per access keeps read data registered
    wire logic req = avs_read_in | avs_write_in;
    wire logic hit_cfg = (avs_address_in == CFG_OFFSET);
    wire logic hit_status = (avs_address_in == STATUS_OFFSET);
    wire logic wr_cfg = avs_write_in & ack_r & hit_cfg;
    assign ack_nxt = req & ~ack_r;
    assign avs_waitrequest_out = req & ~ack_r;
    assign avs_readdata_out = rdata_r;
    assign status_word = {ref_div_clk_out, div_ctrl.bypass,
        osc_core_buffer_en_out, startup_done};
    // Unmapped addresses read zero and drop writes
    assign rdata_nxt = !(avs_read_in && !ack_r) ? rdata_r :
        hit_cfg ? cfg_r :
        hit_status ? DATA_W'(status_word) :
        '0;
    // Byte lanes of the configuration word
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign cfg_nxt[b*8 +: 8] = avs_byteenable_in[b] ?
            avs_writedata_in[b*8 +: 8] : cfg_r[b*8 +: 8];
    end
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ack_r <= 1'b0;
            rdata_r <= '0;
        end else begin
            ack_r <= ack_nxt;
            rdata_r <= rdata_nxt;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cfg_r <= CFG_RESET;
        end else if (wr_cfg) begin
            cfg_r <= cfg_nxt & CFG_WRITE_MASK;
        end
    end
    // ------------------------------------------------------------
    // Reference synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ref_meta_r <= 1'b0;
            ref_sync_r <= 1'b0;
        end else begin
            ref_meta_r <= osc_in_terminal_in;
            ref_sync_r <= ref_meta_r;
        end
    end
    // ------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------
    // Capacitance codes go out unchanged so steps stay monotonic
    assign osc_mode_xtal_out = cfg_r[MODE_BIT];
    assign tuning_cap_in_terminal_out = cfg_r[CAP_IN_LSB +: CAP_W];
    assign tuning_cap_out_terminal_out = cfg_r[CAP_OUT_LSB +: CAP_W];
    assign series_resistor_code_out = cfg_r[RES_LSB +: RES_W];
    // Coupling choice is left to software
    assign buffer_dc_bias_on_out = cfg_r[DC_BIAS_BIT];
    assign single_ended_select_out = cfg_r[SINGLE_BIT];
    assign input_pair_select_out = cfg_r[PAIR_BIT];
    assign div_ctrl.ratio = cfg_r[RATIO_LSB +: RATIO_W];
    assign div_ctrl.run_n = cfg_r[RUN_N_BIT];
    // ------------------------------------------------------------
    // Divider and startup
    // ------------------------------------------------------------
    ref_hf_divider u_div (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .ctrl(div_ctrl),
        .ref_sync_in(ref_sync_r),
        .div_clk_out(ref_div_clk_out)
    );
    osc_startup_seq #(
        .START_CYCLES(START_CYCLES)
    ) u_start (
        .ref_clk_in(ref_clk_in),
        .reset_in(reset_in),
        .gain_code_in(cfg_r[GAIN_LSB +: GAIN_W]),
        .buffer_off_in(cfg_r[BUF_OFF_BIT]),
        .boost_amp_en_out(boost_amp_en_out),
        .buffer_en_out(osc_core_buffer_en_out),
        .startup_done_out(startup_done)
    );
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (reset_in);
    property p_reserved_zero;
        (cfg_r & ~CFG_WRITE_MASK) == '0;
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");
    property p_reset_default;
        $past(reset_in) |-> cfg_r == CFG_RESET;
    endproperty
    a_reset_default: assert property (p_reset_default)
        else $error("configuration not at default after reset");
    property p_mode_write;
        avs_write_in && !avs_waitrequest_out && hit_cfg
        && avs_byteenable_in[0]
        |=> osc_mode_xtal_out == $past(avs_writedata_in[MODE_BIT]);
    endproperty
    a_mode_write: assert property (p_mode_write)
        else $error("mode select not taken from write");
    property p_stopped;
        // First held cycle may still step the output to its set level
        (!div_ctrl.run_n && !div_ctrl.bypass) [*3]
        |-> $stable(ref_div_clk_out);
    endproperty
    a_stopped: assert property (p_stopped)
        else $error("divided clock moves while stopped");
    property p_buffer_off;
        cfg_r[BUF_OFF_BIT] |=> !osc_core_buffer_en_out;
    endproperty
    a_buffer_off: assert property (p_buffer_off)
        else $error("core buffer not forced off");
    property p_buffer_hw;
        !$past(reset_in) && !$past(cfg_r[BUF_OFF_BIT])
        |-> osc_core_buffer_en_out;
    endproperty
    a_buffer_hw: assert property (p_buffer_hw)
        else $error("core buffer not held enabled");
    property p_boost_end;
        startup_done |-> boost_amp_en_out == '0;
    endproperty
    a_boost_end: assert property (p_boost_end)
        else $error("boost amplifiers on after startup");
    property p_answer;
        req && avs_waitrequest_out |=> !avs_waitrequest_out;
    endproperty
    a_answer: assert property (p_answer)
        else $error("slave took more than one wait state");
    property p_first_wait;
        $rose(req) |-> avs_waitrequest_out;
    endproperty
    a_first_wait: assert property (p_first_wait)
        else $error("first cycle of a request not stalled");
    property p_read_hold;
        !avs_read_in |=> $stable(avs_readdata_out);
    endproperty
    a_read_hold: assert property (p_read_hold)
        else $error("read data moved without a read");
    property p_read_cfg;
        avs_read_in && avs_waitrequest_out && hit_cfg
        |=> avs_readdata_out == $past(cfg_r);
    endproperty
    a_read_cfg: assert property (p_read_cfg)
        else $error("read data not the configuration word");
    property p_read_unmapped;
        avs_read_in && avs_waitrequest_out && !hit_cfg && !hit_status
        |=> avs_readdata_out == '0;
    endproperty
    a_read_unmapped: assert property (p_read_unmapped)
        else $error("unmapped read not zero");
    property p_other_addr;
        avs_write_in && !hit_cfg |=> $stable(cfg_r);
    endproperty
    a_other_addr: assert property (p_other_addr)
        else $error("write to other address changed configuration");
    property p_boost_thermo;
        (boost_amp_en_out & (boost_amp_en_out + AMP_COUNT'(1))) == '0;
    endproperty
    a_boost_thermo: assert property (p_boost_thermo)
        else $error("boost enables not a thermometer code");
    property p_boost_gain;
        !startup_done && !$past(reset_in) |-> boost_amp_en_out ==
            (AMP_COUNT'(1) << $past(cfg_r[GAIN_LSB +: GAIN_W]))
            - AMP_COUNT'(1);
    endproperty
    a_boost_gain: assert property (p_boost_gain)
        else $error("boost count differs from gain code");
    property p_held_high;
        !div_ctrl.run_n && !div_ctrl.bypass ##1
        !div_ctrl.run_n && !div_ctrl.bypass |-> ref_div_clk_out;
    endproperty
    a_held_high: assert property (p_held_high)
        else $error("held divider output not high");
    // ------------------------------------------------------------
    // Field write checks
    // ------------------------------------------------------------
    // Taken write as the master sees it, not the internal strobe
    wire logic bus_wr_cfg = avs_write_in & ~avs_waitrequest_out & hit_cfg;
    property p_cap_in_write;
        bus_wr_cfg && avs_byteenable_in[1] |=> tuning_cap_in_terminal_out
            == $past(avs_writedata_in[CAP_IN_LSB +: CAP_W]);
    endproperty
    a_cap_in_write: assert property (p_cap_in_write)
        else $error("inner capacitance code not written");
    property p_cap_out_write;
        bus_wr_cfg && avs_byteenable_in[2] |=> tuning_cap_out_terminal_out
            == $past(avs_writedata_in[CAP_OUT_LSB +: CAP_W]);
    endproperty
    a_cap_out_write: assert property (p_cap_out_write)
        else $error("outer capacitance code not written");
    property p_lane_keep;
        avs_write_in && hit_cfg && !avs_byteenable_in[1]
        |=> $stable(tuning_cap_in_terminal_out);
    endproperty
    a_lane_keep: assert property (p_lane_keep)
        else $error("disabled byte lane changed");
    property p_res_write;
        bus_wr_cfg && avs_byteenable_in[0] |=> series_resistor_code_out
            == $past(avs_writedata_in[RES_LSB +: RES_W]);
    endproperty
    a_res_write: assert property (p_res_write)
        else $error("resistor code not written");
    property p_single_write;
        bus_wr_cfg && avs_byteenable_in[0] |=> single_ended_select_out
            == $past(avs_writedata_in[SINGLE_BIT]);
    endproperty
    a_single_write: assert property (p_single_write)
        else $error("single-ended select not written");
    property p_pair_write;
        bus_wr_cfg && avs_byteenable_in[0] |=> input_pair_select_out
            == $past(avs_writedata_in[PAIR_BIT]);
    endproperty
    a_pair_write: assert property (p_pair_write)
        else $error("input pair select not written");
    property p_dc_bias_write;
        bus_wr_cfg && avs_byteenable_in[0] |=> buffer_dc_bias_on_out
            == $past(avs_writedata_in[DC_BIAS_BIT]);
    endproperty
    a_dc_bias_write: assert property (p_dc_bias_write)
        else $error("bias enable not written");
    property p_ratio_write;
        bus_wr_cfg && avs_byteenable_in[3] |=> div_ctrl.ratio
            == $past(avs_writedata_in[RATIO_LSB +: RATIO_W]);
    endproperty
    a_ratio_write: assert property (p_ratio_write)
        else $error("divide ratio not written");
    property p_run_write;
        bus_wr_cfg && avs_byteenable_in[3] |=> div_ctrl.run_n
            == $past(avs_writedata_in[RUN_N_BIT]);
    endproperty
    a_run_write: assert property (p_run_write)
        else $error("divider run bit not written");
    c_divide: cover property (ref_div_clk_out && !div_ctrl.bypass
        ##1 !ref_div_clk_out);
    c_held_bypass: cover property (!div_ctrl.run_n && div_ctrl.bypass
        && $changed(ref_div_clk_out));
    c_cfg_write: cover property (wr_cfg);
    c_all_boost: cover property (&boost_amp_en_out);
    c_status_read: cover property (avs_read_in && hit_status
        && !avs_waitrequest_out);
endmodule // osc_input_config_divider
`default_nettype wire

// file: osc_cfg_pkg.sv
// Constants of the oscillator input configuration block.
// Assumes one 250 MHz register clock and an Avalon-MM slave port.
`default_nettype none
package osc_cfg_pkg;
    // ------------------------------------------------------------
    // Bus map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam logic [3:0] CFG_OFFSET = 4'h0;
    localparam logic [3:0] STATUS_OFFSET = 4'h4;
    localparam logic [31:0] CFG_RESET = 32'h2068_2845;
    localparam logic [31:0] CFG_WRITE_MASK = 32'h3FFF_7F7F;
    // ------------------------------------------------------------
    // Configuration word fields
    // ------------------------------------------------------------
    localparam int RUN_N_BIT = 29;
    localparam int RATIO_LSB = 24;
    localparam int RATIO_W = 5;
    localparam int GAIN_LSB = 22;
    localparam int GAIN_W = 2;
    localparam int CAP_OUT_LSB = 16;
    localparam int CAP_W = 6;
    localparam int BUF_OFF_BIT = 14;
    localparam int CAP_IN_LSB = 8;
    localparam int RES_LSB = 4;
    localparam int RES_W = 3;
    localparam int DC_BIAS_BIT = 3;
    localparam int MODE_BIT = 2;
    localparam int SINGLE_BIT = 1;
    localparam int PAIR_BIT = 0;
    localparam int AMP_COUNT = 3;
    // ------------------------------------------------------------
    // Status word fields
    // ------------------------------------------------------------
    localparam int ST_DONE_BIT = 0;
    localparam int ST_BUF_BIT = 1;
    localparam int ST_BYPASS_BIT = 2;
    localparam int ST_DIVCLK_BIT = 3;
    localparam int ST_W = 4;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int STARTUP_TIME_NS = 1000;
    localparam int STARTUP_CYCLES = (STARTUP_TIME_NS * CLK_MHZ + 999) / 1000;
endpackage
`default_nettype wire

// file: div_ctrl_if.sv
// Control bundle between the configuration block and its divider.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface div_ctrl_if;
    logic [4:0] ratio;
    logic run_n;
    logic bypass;
    modport owner (output ratio, output run_n, input bypass);
    modport divider (input ratio, input run_n, output bypass);
endinterface
`default_nettype wire

// file: ref_hf_divider.sv
// High-frequency divider of the synchronised reference level.
// Assumes the reference is already two-flop synchronised.
`timescale 1ns/1ps
`default_nettype none
module ref_hf_divider
    import osc_cfg_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    div_ctrl_if.divider ctrl,
    input wire logic ref_sync_in,
    output logic div_clk_out
);
    logic ref_prev_r;
    logic [4:0] cnt_r;
    logic [4:0] cnt_nxt;
    logic out_r;
    logic out_nxt;
    wire logic rise = ref_sync_in & ~ref_prev_r;
    wire logic [4:0] last = ctrl.ratio - 5'h01;
    wire logic [4:0] half = 5'((6'(ctrl.ratio) + 6'h01) >> 1);
    // Reserved ratio one behaves as a pass-through
    assign ctrl.bypass = (ctrl.ratio < 5'h02);
    assign cnt_nxt = (cnt_r == last) ? 5'h00 : cnt_r + 5'h01;
    assign out_nxt = (cnt_nxt < half);
    // Bypass keeps running even when held
    assign div_clk_out = ctrl.bypass ? ref_prev_r : out_r;
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ref_prev_r <= 1'b0;
            cnt_r <= 5'h00;
            out_r <= 1'b1;
        end else begin
            ref_prev_r <= ref_sync_in;
            if (!ctrl.run_n) begin
                cnt_r <= 5'h00;
                out_r <= 1'b1;
            end else if (rise && !ctrl.bypass) begin
                cnt_r <= cnt_nxt;
                out_r <= out_nxt;
            end
        end
    end
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_held_set;
        @(posedge ref_clk_in) disable iff (reset_in)
        !ctrl.run_n |=> (cnt_r == 5'h00) && out_r;
    endproperty
    a_held_set: assert property (p_held_set)
        else $error("divider not held in set state");
    property p_wrap;
        @(posedge ref_clk_in) disable iff (reset_in)
        ctrl.run_n && !ctrl.bypass && rise && cnt_r == last
        ##1 ctrl.run_n |-> cnt_r == 5'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("divider count did not wrap at ratio");
    property p_bypass;
        @(posedge ref_clk_in) disable iff (reset_in)
        ctrl.bypass && !$past(reset_in)
        |-> div_clk_out == $past(ref_sync_in);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("bypass does not follow reference");
endmodule // ref_hf_divider
`default_nettype wire

// file: osc_startup_seq.sv
// Startup sequencer: gain boost window and core buffer enable.
// Assumes reset_in is the power-on reset of the device.
`timescale 1ns/1ps
`default_nettype none
module osc_startup_seq
    import osc_cfg_pkg::*;
#(
    parameter int START_CYCLES = STARTUP_CYCLES
)
(
    input wire logic ref_clk_in,
    input wire logic reset_in,
    input wire logic [GAIN_W-1:0] gain_code_in,
    input wire logic buffer_off_in,
    output logic [AMP_COUNT-1:0] boost_amp_en_out,
    output logic buffer_en_out,
    output logic startup_done_out
);
    logic [12:0] cnt_r;
    logic done_r;
    logic buf_en_r;
    logic [AMP_COUNT-1:0] amp_r;
    if (START_CYCLES < 1 || START_CYCLES > 8191) begin : g_bad
        $error("START_CYCLES out of range");
    end
    wire logic cnt_end = (cnt_r == 13'(START_CYCLES - 1));
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            cnt_r <= 13'h0000;
            done_r <= 1'b0;
        end else if (!done_r) begin
            cnt_r <= cnt_r + 13'h0001;
            done_r <= cnt_end;
        end
    end
    // Hardware enable, follows the inverted buffer-off bit one edge later
    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            buf_en_r <= 1'b0;
        end else begin
            buf_en_r <= ~buffer_off_in;
        end
    end
    // One flop per boosting amplifier
    for (genvar i = 0; i < AMP_COUNT; i++) begin : g_amp
        always_ff @(posedge ref_clk_in) begin
            if (reset_in) begin
                amp_r[i] <= 1'b0;
            end else begin
                amp_r[i] <= ~done_r & ~cnt_end
                    & (gain_code_in > GAIN_W'(i));
            end
        end
    end
    assign boost_amp_en_out = amp_r;
    assign buffer_en_out = buf_en_r;
    assign startup_done_out = done_r;
endmodule // osc_startup_seq
`default_nettype wire

// file: ref_source.sv
// Partner model: crystal or external reference level source.
// Assumes it is clocked by the register clock of the design.
`timescale 1ns/1ps
`default_nettype none
module ref_source #(
    parameter int HALF = 3
)
(
    input wire logic clk_in,
    input wire logic run_in,
    output logic level_out
);
    int cnt;
    // ------------------------------------------------------------
    // Level toggles every HALF clocks
    // ------------------------------------------------------------
    // Stands low while stopped, so no stale edge reaches the divider
    always_ff @(posedge clk_in) begin
        if (!run_in) begin
            cnt <= 0;
            level_out <= 1'b0;
        end else if (cnt == HALF - 1) begin
            cnt <= 0;
            level_out <= ~level_out;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule // ref_source
`default_nettype wire

// file: tb_top.sv
// Self-checking bench of the oscillator configuration block.
// Assumes the design files and ref_source are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import osc_cfg_pkg::*;
    localparam int HALF = 3;
    logic ref_clk_in, reset_in, avs_read_in, avs_write_in, run;
    logic [ADDR_W-1:0] avs_address_in;
    logic [DATA_W-1:0] avs_writedata_in, avs_readdata_out, q;
    logic [3:0] avs_byteenable_in;
    logic avs_waitrequest_out, ref_level, ref_div_clk_out, mode;
    logic [CAP_W-1:0] cap_in, cap_out;
    logic [AMP_COUNT-1:0] boost;
    logic [RES_W-1:0] res;
    logic dc_bias, single, pair, buf_en;
    int mismatches, checked, p, r;
    int r_list[4] = '{0, 2, 3, 31};
    // ------------------------------------------------------------
    // Design and reference source
    // ------------------------------------------------------------
    // Short startup window keeps the run brief
    osc_input_config_divider #(.START_CYCLES(4)) DUT (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in),
        .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
        .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
        .avs_byteenable_in(avs_byteenable_in),
        .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out),
        .osc_in_terminal_in(ref_level), .ref_div_clk_out(ref_div_clk_out),
        .osc_mode_xtal_out(mode), .tuning_cap_in_terminal_out(cap_in),
        .tuning_cap_out_terminal_out(cap_out), .boost_amp_en_out(boost),
        .series_resistor_code_out(res), .buffer_dc_bias_on_out(dc_bias),
        .single_ended_select_out(single), .input_pair_select_out(pair),
        .osc_core_buffer_en_out(buf_en));
    ref_source #(.HALF(HALF)) partner (.clk_in(ref_clk_in), .run_in(run),
        .level_out(ref_level));
    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One Avalon access; request held until waitrequest samples low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d, input logic [3:0] be);
        int n;
        n = 0;
        avs_address_in <= a;
        avs_writedata_in <= d;
        avs_byteenable_in <= be;
        avs_write_in <= wr;
        avs_read_in <= !wr;
        do begin
            @(posedge ref_clk_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 50);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (n >= 50) begin
            mismatches++;
            end_of_test();
        end
        @(posedge ref_clk_in);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 4'h0);
        chk(q, exp);
    endtask
    task automatic wr(input logic [31:0] d, input logic [3:0] be);
        bus(1'b1, CFG_OFFSET, d, be);
    endtask
    // Field outputs against the word they should mirror
    task automatic chk_outs(input logic [31:0] w);
        chk(32'({mode, cap_in, cap_out, res, dc_bias, single, pair}),
            32'({w[2], w[13:8], w[21:16], w[6:4], w[3], w[1], w[0]}));
    endtask
    // Cycles between two rising edges of the divided clock, 0 if none
    task automatic period(output int pr);
        int t0, k;
        logic prev;
        pr = 0;
        t0 = -1;
        prev = ref_div_clk_out;
        for (k = 0; k < 500 && pr == 0; k++) begin
            @(posedge ref_clk_in);
            if (prev === 1'b0 && ref_div_clk_out === 1'b1) begin
                if (t0 >= 0) pr = k - t0;
                t0 = k;
            end
            prev = ref_div_clk_out;
        end
    endtask
    task automatic do_reset();
        reset_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        repeat (2) @(posedge ref_clk_in);
    endtask
    // ------------------------------------------------------------
    // Clock and main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        reset_in = 1'b1;
        avs_read_in = 1'b0;
        avs_write_in = 1'b0;
        avs_address_in = 4'h0;
        avs_writedata_in = 32'h0000_0000;
        avs_byteenable_in = 4'h0;
        run = 1'b0;
        mismatches = 0;
        checked = 0;
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        run <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        chk(32'(boost), 32'h0000_0001);
        chk(32'(buf_en), 32'h0000_0001);
        chk_outs(32'h2068_2845);
        rd(CFG_OFFSET, 32'h2068_2845);
        repeat (10) @(posedge ref_clk_in);
        chk(32'(boost), 32'h0000_0000);
        rd(STATUS_OFFSET, 32'h0000_0007);
        rd(4'h8, 32'h0000_0000);
        bus(1'b1, 4'h8, 32'hFFFF_FFFF, 4'hF);
        bus(1'b1, STATUS_OFFSET, 32'h0000_0000, 4'hF);
        rd(CFG_OFFSET, 32'h2068_2845);
        foreach (r_list[i]) begin
            r = r_list[i];
            wr(32'h2068_2845 | (32'(r) << 24), 4'hF);
            period(p);
            period(p);
            chk(32'(p), 32'((r == 0 ? 1 : r) * 2 * HALF));
        end
        wr(32'h0368_2845, 4'hF);
        repeat (50) @(posedge ref_clk_in);
        period(p);
        chk(32'(p), 32'h0000_0000);
        chk(32'(ref_div_clk_out), 32'h0000_0001);
        wr(32'h0068_2845, 4'hF);
        period(p);
        period(p);
        chk(32'(p), 32'(2 * HALF));
        wr(32'hFFFF_FFFF, 4'hF);
        rd(CFG_OFFSET, 32'h3FFF_7F7F);
        chk_outs(32'h3FFF_7F7F);
        chk(32'(buf_en), 32'h0000_0000);
        wr(32'h0000_0000, 4'h1);
        rd(CFG_OFFSET, 32'h3FFF_7F00);
        chk_outs(32'h3FFF_7F00);
        wr(32'h2040_004A, 4'hF);
        chk_outs(32'h2040_004A);
        // Buffer enable follows the cleared bit one edge later
        @(posedge ref_clk_in);
        chk(32'(buf_en), 32'h0000_0001);
        do_reset();
        rd(CFG_OFFSET, 32'h2068_2845);
        // Gain three written inside the short startup window
        reset_in <= 1'b1;
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        wr(32'h20E8_2845, 4'hF);
        @(posedge ref_clk_in);
        chk(32'(boost), 32'h0000_0007);
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
